/* File: core/qpc_classifier.sv */
`timescale 1ns/1ps
`default_nettype none

module qpc_classifier (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // AXI4-Lite register slave.
  input wire logic [8:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [8:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Packet descriptors from the ingress parser.
  input wire logic desc_valid_in,
  output logic desc_ready_out,
  input wire logic [qpc_pkg::DESC_W-1:0] desc_data_in,
  // Classified packets towards the egress queues.
  output logic enq_valid_out,
  input wire logic enq_ready_in,
  output logic [2:0] enq_port_out,
  output logic [1:0] enq_queue_out,
  output logic [1:0] enq_prio_out,
  // Transmit scheduling, one lane per egress port.
  input wire logic [19:0] q_nonempty_in,
  input wire logic [4:0] tx_req_in,
  output logic [4:0] tx_grant_out,
  output logic [9:0] tx_grant_queue_out
);

  // Ports outside 0 to 4 are folded onto port 0 so indexing stays in range.
  function automatic logic [2:0] clamp_port(input logic [2:0] p);
    return (p < 3'h5) ? p : 3'h0;
  endfunction : clamp_port

  // Register storage, one set per port, then the global maps and the packet counter.
  // Weights keep bit 7 at zero.
  logic [7:0] ctrl0_q [qpc_pkg::NUM_PORTS]; // Low split bit, port priority, enables.
  logic [7:0] ctrl9_q [qpc_pkg::NUM_PORTS]; // High split bit and scheduling mode.
  logic [7:0] wt_q [qpc_pkg::NUM_PORTS][qpc_pkg::NUM_QUEUES]; // Weights, index 0 holds queue 3.
  logic [7:0] map_lo_q; // Tag priorities 0 to 3.
  logic [7:0] map_hi_q; // Tag priorities 4 to 7.
  logic [7:0] twoq_q; // Two-queue map in bits 7:6.
  logic [7:0] tos_q [16]; // DSCP map, two bits per code point.
  logic [15:0] pkt_cnt_q; // Packets classified since reset.

  // Bus handshake state.
  logic awready_q;
  logic wready_q;
  logic [8:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wstrb0_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // Output stage.
  logic enq_valid_q;
  logic [2:0] enq_port_q;
  logic [1:0] enq_queue_q;
  logic [1:0] enq_prio_q;

  // Address decoding shared by the write and the read path.
  // Port blocks are 32 bytes apart.
  function automatic logic is_port(input logic [8:0] a);
    return !a[8] && (a[7:5] < 3'h5) && (a[4:2] <= qpc_pkg::K_LAST);
  endfunction : is_port
  function automatic logic is_tos(input logic [8:0] a);
    return a[8] && (a[7:6] == 2'h0);
  endfunction : is_tos
  function automatic logic is_mapped(input logic [8:0] a);
    return is_port(a) || is_tos(a) || (a == qpc_pkg::A_MAP_LO) || (a == qpc_pkg::A_MAP_HI) ||
           (a == qpc_pkg::A_TWOQ) || (a == qpc_pkg::A_STATUS);
  endfunction : is_mapped

  // Write path: address and data may arrive in either order.
  // The store lands with the response.
  wire aw_hs = s_axi_awvalid_in && awready_q;
  wire w_hs = s_axi_wvalid_in && wready_q;
  wire wr_go = !awready_q && !wready_q && !bvalid_q;
  wire wr_en = wr_go && wstrb0_q;
  wire [2:0] wr_port = awaddr_q[7:5];
  wire [2:0] wr_k = awaddr_q[4:2];

  // Read data mux.
  // Unmapped words read as zero.
  wire [2:0] rd_port = s_axi_araddr_in[7:5];
  wire [2:0] rd_k = s_axi_araddr_in[4:2];
  wire [1:0] rd_wi = 2'(rd_k - qpc_pkg::K_WEIGHT0);
  wire [7:0] rd_port_val = (rd_k == qpc_pkg::K_CTRL0) ? ctrl0_q[rd_port] :
                           (rd_k == qpc_pkg::K_CTRL9) ? ctrl9_q[rd_port] : wt_q[rd_port][rd_wi];
  wire [7:0] rd_byte = is_port(s_axi_araddr_in) ? rd_port_val :
                       is_tos(s_axi_araddr_in) ? tos_q[s_axi_araddr_in[5:2]] :
                       (s_axi_araddr_in == qpc_pkg::A_MAP_LO) ? map_lo_q :
                       (s_axi_araddr_in == qpc_pkg::A_MAP_HI) ? map_hi_q :
                       (s_axi_araddr_in == qpc_pkg::A_TWOQ) ? twoq_q : 8'h00;
  wire [4:0] fifo_count;
  wire [31:0] rd_word = (s_axi_araddr_in == qpc_pkg::A_STATUS) ? {11'h000, fifo_count, pkt_cnt_q} :
                        {24'h000000, rd_byte};

  assign s_axi_awready_out = awready_q;
  assign s_axi_wready_out = wready_q;
  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out = bresp_q;
  assign s_axi_arready_out = arready_q;
  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rdata_out = rdata_q;
  assign s_axi_rresp_out = rresp_q;

  // Write channel capture and response; one write is held until its response is taken.
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      awaddr_q <= 9'h000;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= qpc_pkg::RESP_OKAY;
    end
    else
    begin
      if (aw_hs)
      begin
        awready_q <= 1'b0;
        awaddr_q <= {s_axi_awaddr_in[8:2], 2'h0};
      end
      if (w_hs)
      begin
        wready_q <= 1'b0;
        wdata_q <= s_axi_wdata_in[7:0];
        wstrb0_q <= s_axi_wstrb_in[0];
      end
      if (wr_go)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= is_mapped(awaddr_q) ? qpc_pkg::RESP_OKAY : qpc_pkg::RESP_SLVERR;
      end
      if (bvalid_q && s_axi_bready_in)
      begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // Read channel; the data word is captured with the address.
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= qpc_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid_in && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= is_mapped(s_axi_araddr_in) ? qpc_pkg::RESP_OKAY : qpc_pkg::RESP_SLVERR;
    end
    else if (rvalid_q && s_axi_rready_in)
    begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // Per-port settings, each port with its own copy.
  always_ff @(posedge sys_clk_in)
  begin
    for (int p = 0; p < qpc_pkg::NUM_PORTS; p++)
    begin
      if (!rst_n_in)
      begin
        ctrl0_q[p] <= qpc_pkg::RST_CTRL0;
        ctrl9_q[p] <= qpc_pkg::RST_CTRL9;
        wt_q[p][0] <= qpc_pkg::RST_W3;
        wt_q[p][1] <= qpc_pkg::RST_W2;
        wt_q[p][2] <= qpc_pkg::RST_W1;
        wt_q[p][3] <= qpc_pkg::RST_W0;
      end
      else if (wr_en && is_port(awaddr_q) && (wr_port == 3'(p)))
      begin
        if (wr_k == qpc_pkg::K_CTRL0)
          ctrl0_q[p] <= wdata_q;
        else if (wr_k == qpc_pkg::K_CTRL9)
          ctrl9_q[p] <= wdata_q;
        else
          wt_q[p][2'(wr_k - qpc_pkg::K_WEIGHT0)] <= {1'b0, wdata_q[6:0]};
      end
    end
  end

  // Global maps; the spare bits 5:0 of the two-queue map read as zero.
  // A write with lane 0 off is not stored.
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      map_lo_q <= qpc_pkg::RST_MAP_LO;
      map_hi_q <= qpc_pkg::RST_MAP_HI;
      twoq_q <= qpc_pkg::RST_TWOQ;
      for (int i = 0; i < 16; i++)
        tos_q[i] <= qpc_pkg::RST_TOS;
    end
    else if (wr_en)
    begin
      if (awaddr_q == qpc_pkg::A_MAP_LO) map_lo_q <= wdata_q;
      if (awaddr_q == qpc_pkg::A_MAP_HI) map_hi_q <= wdata_q;
      if (awaddr_q == qpc_pkg::A_TWOQ) twoq_q <= {wdata_q[7:6], 6'h00};
      if (is_tos(awaddr_q)) tos_q[awaddr_q[5:2]] <= wdata_q;
    end
  end

  // Descriptor FIFO in front of the classifier.
  // It absorbs bursts while egress stalls.
  wire fifo_valid;
  wire [qpc_pkg::DESC_W-1:0] head;
  wire fifo_pop = !enq_valid_q || enq_ready_in;
  qpc_fifo #(.WIDTH(qpc_pkg::DESC_W), .DEPTH(qpc_pkg::FIFO_DEPTH)) u_fifo (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(desc_valid_in),
    .in_ready_out(desc_ready_out),
    .in_data_in(desc_data_in),
    .out_valid_out(fifo_valid),
    .out_ready_in(fifo_pop),
    .out_data_out(head),
    .count_out(fifo_count)
  );

  // Classification of the FIFO head.
  // DSCP beats the tag; the tag beats the port, but port level 3 beats both.
  wire [2:0] ing = clamp_port(head[qpc_pkg::D_ING_LSB +: qpc_pkg::PORT_W]);
  wire [2:0] dst = clamp_port(head[qpc_pkg::D_DEST_LSB +: qpc_pkg::PORT_W]);
  wire [2:0] tag_pri = head[qpc_pkg::D_TAGPRI_LSB +: qpc_pkg::TAGPRI_W];
  wire [5:0] dscp = head[qpc_pkg::D_DSCP_LSB +: qpc_pkg::DSCP_W];
  wire [7:0] ing_c0 = ctrl0_q[ing];
  wire [1:0] port_prio = ing_c0[qpc_pkg::C0_PPRIO_LSB +: qpc_pkg::PRIO_W];
  wire [7:0] map_sel = tag_pri[2] ? map_hi_q : map_lo_q;
  wire [1:0] dot1p_prio = map_sel[{tag_pri[1:0], 1'b0} +: 2];
  wire [7:0] tos_sel = tos_q[dscp[5:2]];
  wire [1:0] dscp_prio = tos_sel[{dscp[1:0], 1'b0} +: 2];
  wire use_dscp = ing_c0[qpc_pkg::C0_DSCP_EN] && head[qpc_pkg::D_IP_BIT];
  wire use_dot1p = ing_c0[qpc_pkg::C0_DOT1P_EN] && head[qpc_pkg::D_TAGGED_BIT];
  // Untagged packets without DSCP fall through to the port level, which is 0 when unset.
  wire [1:0] base_prio = use_dscp ? dscp_prio : use_dot1p ? dot1p_prio : port_prio;
  wire [1:0] prio = (port_prio == 2'h3) ? 2'h3 : base_prio;
  // Queue count comes from the destination port's own two bits.
  wire [1:0] qcount_dst = {ctrl9_q[dst][qpc_pkg::C9_SPLIT_HI], ctrl0_q[dst][qpc_pkg::C0_SPLIT_LO]};
  wire [1:0] twoq_map = twoq_q[qpc_pkg::TWOQ_LSB +: 2];
  wire [1:0] queue = (qcount_dst == qpc_pkg::QC_FOUR) ? prio :
                     (qcount_dst == qpc_pkg::QC_TWO) ? {1'b0, prio >= twoq_map} : 2'h0;

  assign enq_valid_out = enq_valid_q;
  assign enq_port_out = enq_port_q;
  assign enq_queue_out = enq_queue_q;
  assign enq_prio_out = enq_prio_q;

  // Output register; it refills in the cycle it is taken so no bubble is lost.
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      enq_valid_q <= 1'b0;
      enq_port_q <= 3'h0;
      enq_queue_q <= 2'h0;
      enq_prio_q <= 2'h0;
      pkt_cnt_q <= 16'h0000;
    end
    else if (fifo_pop)
    begin
      enq_valid_q <= fifo_valid;
      if (fifo_valid)
      begin
        enq_port_q <= dst;
        enq_queue_q <= queue;
        enq_prio_q <= prio;
        pkt_cnt_q <= pkt_cnt_q + 16'h0001;
      end
    end
  end

  // One scheduler per egress port, each fed from that port's settings.
  // Grants are one-cycle pulses.
  genvar gp;
  generate
    for (gp = 0; gp < qpc_pkg::NUM_PORTS; gp++)
    begin : g_port
      qpc_cfg_if cfg_i ();
      assign cfg_i.qcount = {ctrl9_q[gp][qpc_pkg::C9_SPLIT_HI], ctrl0_q[gp][qpc_pkg::C0_SPLIT_LO]};
      assign cfg_i.wfq_en = ctrl9_q[gp][qpc_pkg::C9_WFQ_EN];
      for (genvar q = 0; q < qpc_pkg::NUM_QUEUES; q++)
      begin : g_w
        assign cfg_i.weight[q] = wt_q[gp][3-q][6:0];
      end
      qpc_sched u_sched (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .cfg(cfg_i),
        .nonempty_in(q_nonempty_in[gp*4 +: 4]),
        .req_in(tx_req_in[gp]),
        .grant_out(tx_grant_out[gp]),
        .grant_queue_out(tx_grant_queue_out[gp*2 +: 2])
      );
    end
  endgenerate

endmodule : qpc_classifier

`default_nettype wire

/* File: core/qpc_pkg.sv */
package qpc_pkg;

  // Number of switch ports whose settings are held, and queues per port.
  localparam int NUM_PORTS = 5;
  localparam int NUM_QUEUES = 4;

  // Widths of the descriptor, enqueue and weight fields, and the FIFO depth.
  localparam int PORT_W = 3;
  localparam int QUEUE_W = 2;
  localparam int PRIO_W = 2;
  localparam int TAGPRI_W = 3;
  localparam int DSCP_W = 6;
  localparam int WEIGHT_W = 7;
  localparam int DESC_W = 17;
  localparam int FIFO_DEPTH = 16;

  // Descriptor layout: {ingress, dest, tagged, tag_pri, is_ip, dscp}.
  localparam int D_DSCP_LSB = 0;
  localparam int D_IP_BIT = 6;
  localparam int D_TAGPRI_LSB = 7;
  localparam int D_TAGGED_BIT = 10;
  localparam int D_DEST_LSB = 11;
  localparam int D_ING_LSB = 14;

  // Word offsets inside one port's block of eight words.
  localparam logic [2:0] K_CTRL0 = 3'h0;
  localparam logic [2:0] K_CTRL9 = 3'h1;
  localparam logic [2:0] K_WEIGHT0 = 3'h2;
  localparam logic [2:0] K_LAST = 3'h5;

  // Global byte addresses.
  localparam logic [8:0] A_MAP_LO = 9'h0C0;
  localparam logic [8:0] A_MAP_HI = 9'h0C4;
  localparam logic [8:0] A_TWOQ = 9'h0C8;
  localparam logic [8:0] A_STATUS = 9'h140;

  // Field positions in port control 0, port control 9 and the two-queue map.
  localparam int C0_SPLIT_LO = 0;
  localparam int C0_PPRIO_LSB = 3;
  localparam int C0_DOT1P_EN = 5;
  localparam int C0_DSCP_EN = 6;
  localparam int C9_SPLIT_HI = 1;
  localparam int C9_WFQ_EN = 2;
  localparam int TWOQ_LSB = 6;

  // Queue count settings.
  localparam logic [1:0] QC_ONE = 2'h0;
  localparam logic [1:0] QC_TWO = 2'h1;
  localparam logic [1:0] QC_FOUR = 2'h2;

  // Reset values.
  localparam logic [7:0] RST_CTRL0 = 8'h00;
  localparam logic [7:0] RST_CTRL9 = 8'h00;
  localparam logic [7:0] RST_W3 = 8'h08;
  localparam logic [7:0] RST_W2 = 8'h04;
  localparam logic [7:0] RST_W1 = 8'h02;
  localparam logic [7:0] RST_W0 = 8'h01;
  localparam logic [7:0] RST_MAP_LO = 8'h50;
  localparam logic [7:0] RST_MAP_HI = 8'hFA;
  localparam logic [7:0] RST_TWOQ = 8'h80;
  localparam logic [7:0] RST_TOS = 8'h00;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : qpc_pkg

/* File: core/qpc_cfg_if.sv */
`timescale 1ns/1ps
`default_nettype none

// Per-port scheduling settings passed from the register file to one scheduler.
interface qpc_cfg_if;
  logic [1:0] qcount; // Queue count setting of the port.
  logic wfq_en; // High selects weighted fair queuing.
  logic [qpc_pkg::WEIGHT_W-1:0] weight [qpc_pkg::NUM_QUEUES]; // Packets per round for each queue.
  modport src (output qcount, output wfq_en, output weight);
  modport sched (input qcount, input wfq_en, input weight);
endinterface : qpc_cfg_if

`default_nettype wire

/* File: core/qpc_fifo.sv */
`timescale 1ns/1ps
`default_nettype none

// Flip-flop FIFO; the ready on the filling side is registered.
module qpc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out,
  output logic [$clog2(DEPTH):0] count_out
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH]; // Storage words.
  logic [AW-1:0] wr_ptr_q; // Next slot to fill.
  logic [AW-1:0] rd_ptr_q; // Oldest slot.
  logic [AW:0] count_q; // Words held.
  logic ready_q; // Registered not-full.
  wire push = in_valid_in && ready_q;
  wire pop = (count_q != '0) && out_ready_in;
  wire [AW:0] count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);

  assign in_ready_out = ready_q;
  assign out_valid_out = (count_q != '0);
  assign out_data_out = mem_q[rd_ptr_q];
  assign count_out = count_q;

  // Pointers and level; ready follows the next level so a full FIFO refuses at once.
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      ready_q <= 1'b1;
    end
    else
    begin
      wr_ptr_q <= wr_ptr_q + AW'(push);
      rd_ptr_q <= rd_ptr_q + AW'(pop);
      count_q <= count_d;
      ready_q <= (count_d != FULL);
    end
  end

  // Data words need no reset; they are read only while counted.
  always_ff @(posedge sys_clk_in)
  begin
    if (push)
    begin
      mem_q[wr_ptr_q] <= in_data_in;
    end
  end
endmodule : qpc_fifo

`default_nettype wire

/* File: core/qpc_sched.sv */
`timescale 1ns/1ps
`default_nettype none

// Transmit queue selection for one egress port.
module qpc_sched (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  qpc_cfg_if.sched cfg,
  input wire logic [3:0] nonempty_in,
  input wire logic req_in,
  output logic grant_out,
  output logic [1:0] grant_queue_out
);
  // Highest numbered set bit, which is the most urgent queue.
  function automatic logic [1:0] highest(input logic [3:0] m);
    logic [1:0] r;
    r = 2'h0;
    for (int i = 0; i < 4; i++)
    begin
      if (m[i]) r = 2'(i);
    end
    return r;
  endfunction : highest

  // First set bit strictly below cur, wrapping round to cur itself last.
  function automatic logic [1:0] below(input logic [3:0] m, input logic [1:0] cur);
    logic [1:0] r;
    logic [1:0] idx;
    r = cur;
    for (int k = 4; k >= 1; k--)
    begin
      idx = cur - 2'(k);
      if (m[idx]) r = idx;
    end
    return r;
  endfunction : below

  logic grant_q; // One-cycle grant pulse.
  logic [1:0] gq_q; // Granted queue.
  logic [1:0] cur_q; // Queue being served in this round.
  logic [qpc_pkg::WEIGHT_W-1:0] credit_q; // Packets already taken from cur_q.

  // Queues outside the active count are never looked at.
  wire [3:0] mask = (cfg.qcount == qpc_pkg::QC_FOUR) ? 4'hF :
                    (cfg.qcount == qpc_pkg::QC_TWO) ? 4'h3 : 4'h1;
  wire [3:0] m = nonempty_in & mask;
  wire split = (cfg.qcount == qpc_pkg::QC_TWO) || (cfg.qcount == qpc_pkg::QC_FOUR);
  wire stay = m[cur_q] && (credit_q < cfg.weight[cur_q]);
  wire [1:0] nxt = below(m, cur_q);

  assign grant_out = grant_q;
  assign grant_queue_out = gq_q;

  // A request with nothing queued gives no grant.
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      grant_q <= 1'b0;
      gq_q <= 2'h0;
      cur_q <= 2'h0;
      credit_q <= '0;
    end
    else
    begin
      grant_q <= req_in && (m != 4'h0);
      if (req_in && (m != 4'h0))
      begin
        if (!split)
        begin
          gq_q <= 2'h0;
        end
        else if (!cfg.wfq_en)
        begin
          gq_q <= highest(m);
        end
        else if (stay)
        begin
          gq_q <= cur_q;
          credit_q <= credit_q + 7'h01;
        end
        else
        begin
          gq_q <= nxt;
          cur_q <= nxt;
          credit_q <= 7'h01;
        end
      end
    end
  end
endmodule : qpc_sched

`default_nettype wire

/* File: verification/qpc_egress_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Egress queue side: takes classified packets, and can stall on request.
module qpc_egress_model (
  input wire logic sys_clk_in,
  input wire logic stall_in,
  input wire logic enq_valid_in,
  output logic enq_ready_out,
  input wire logic [2:0] enq_port_in,
  input wire logic [1:0] enq_queue_in,
  input wire logic [1:0] enq_prio_in
);
  // Entries taken as {port, queue, prio}, oldest first.
  logic [6:0] got [$];

  initial enq_ready_out = 1'b1;

  // Ready follows the stall request one edge late, as a registered buffer flag would.
  always @(posedge sys_clk_in)
  begin
    if (enq_valid_in && enq_ready_out)
      got.push_back({enq_port_in, enq_queue_in, enq_prio_in});
    enq_ready_out <= !stall_in;
  end
endmodule : qpc_egress_model

`default_nettype wire

/* File: verification/qpc_chk.sv */
`timescale 1ns/1ps
`default_nettype none

// Pin-level checks of the classifier.
module qpc_chk (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wready_out,
  input wire logic s_axi_bvalid_out,
  input wire logic enq_valid_out,
  input wire logic enq_ready_in,
  input wire logic [2:0] enq_port_out,
  input wire logic [1:0] enq_queue_out,
  input wire logic [1:0] enq_prio_out,
  input wire logic [19:0] q_nonempty_in,
  input wire logic [4:0] tx_req_in,
  input wire logic [4:0] tx_grant_out,
  input wire logic [9:0] tx_grant_queue_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  // Occupancy as the scheduler saw it at the request edge.
  logic [19:0] ne_q;

  always_ff @(posedge sys_clk_in)
    ne_q <= q_nonempty_in;

  chk_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read answer late");
  chk_read_once: assert property (s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out)
    else $error("read answered twice");
  chk_write_busy: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write taken during response");
  chk_enq_hold: assert property (enq_valid_out && !enq_ready_in |=>
    enq_valid_out && $stable({enq_port_out, enq_queue_out, enq_prio_out}))
    else $error("enqueue dropped while stalled");
  chk_enq_port: assert property (enq_valid_out |-> enq_port_out < 3'h5)
    else $error("enqueue port out of range");
  chk_grant_cause: assert property ((tx_grant_out & ~$past(tx_req_in)) == 5'h00)
    else $error("grant without request");
  chk_grant_busy: assert property (tx_grant_out[0] |-> ne_q[tx_grant_queue_out[1:0]])
    else $error("grant to empty queue");
  chk_grant_idle: assert property (tx_req_in[0] && q_nonempty_in[3:0] == 4'h0 |=> !tx_grant_out[0])
    else $error("grant with all queues empty");

  cover property (enq_valid_out && !enq_ready_in);
  cover property (tx_grant_out[0] && tx_grant_queue_out[1:0] == 2'h3);
  cover property (s_axi_rvalid_out && s_axi_rready_in);
endmodule : qpc_chk

bind qpc_classifier qpc_chk i_qpc_chk (.*);

`default_nettype wire

/* File: verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic sys_clk_in = 1'b0, rst_n_in = 1'b0, stall = 1'b0;
  logic [8:0] s_axi_awaddr_in = 9'h000, s_axi_araddr_in = 9'h000;
  logic [31:0] s_axi_wdata_in = 32'h00000000;
  logic [3:0] s_axi_wstrb_in = 4'hF;
  logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
  logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0, desc_valid_in = 1'b0;
  logic [16:0] desc_data_in = 17'h00000;
  logic [19:0] q_nonempty_in = 20'h00000;
  logic [4:0] tx_req_in = 5'h00;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
  logic desc_ready_out, enq_valid_out, enq_ready_in;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, enq_queue_out, enq_prio_out;
  logic [31:0] s_axi_rdata_out;
  logic [2:0] enq_port_out;
  logic [4:0] tx_grant_out;
  logic [9:0] tx_grant_queue_out;
  int n_fail = 0, n_checks = 0;

  qpc_classifier i_qpc_classifier (.*);

  qpc_egress_model i_qpc_egress_model (.sys_clk_in(sys_clk_in), .stall_in(stall), .enq_valid_in(enq_valid_out),
    .enq_ready_out(enq_ready_in), .enq_port_in(enq_port_out), .enq_queue_in(enq_queue_out),
    .enq_prio_in(enq_prio_out));

  always #10 sys_clk_in = ~sys_clk_in;

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  // Counts one comparison and reports it at once when it fails.
  task automatic check(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1)
    begin
      n_fail++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask : check

  // Register write; each channel is released at its own handshake.
  task automatic wr(input logic [8:0] a, input logic [7:0] d, input logic [1:0] r);
    @(posedge sys_clk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= {24'h000000, d};
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    do
    begin
      @(posedge sys_clk_in);
      if (s_axi_awready_out)
        s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out)
        s_axi_wvalid_in <= 1'b0;
    end
    while (!s_axi_bvalid_out);
    s_axi_bready_in <= 1'b0;
    check(s_axi_bresp_out === r, "write response");
  endtask : wr

  // Register read; data is only compared on an OKAY answer.
  task automatic rd(input logic [8:0] a, input logic [7:0] e, input logic [1:0] r);
    @(posedge sys_clk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do
    begin
      @(posedge sys_clk_in);
      if (s_axi_arready_out)
        s_axi_arvalid_in <= 1'b0;
    end
    while (!s_axi_rvalid_out);
    s_axi_rready_in <= 1'b0;
    check(s_axi_rresp_out === r && (r != 2'h0 || s_axi_rdata_out === {24'h000000, e}), "read");
  endtask : rd

  function automatic logic [16:0] dsc(input int i, input int o, input int tg, input int tp, input int ipd);
    return {i[2:0], o[2:0], tg[0], tp[2:0], ipd[6:0]};
  endfunction : dsc

  // Sends one descriptor and compares the single enqueue it yields.
  task automatic cls(input logic [16:0] d, input logic [6:0] e);
    @(posedge sys_clk_in);
    desc_valid_in <= 1'b1;
    desc_data_in <= d;
    do
      @(posedge sys_clk_in);
    while (!desc_ready_out);
    desc_valid_in <= 1'b0;
    for (int t = 0; t < 20 && i_qpc_egress_model.got.size() == 0; t++)
      @(posedge sys_clk_in);
    check(i_qpc_egress_model.got.size() == 1 && i_qpc_egress_model.got.pop_front() === e, "class");
  endtask : cls

  // One scheduling request on port p; g is whether a grant is due.
  task automatic tx(input int p, input logic g, output logic [1:0] q);
    @(posedge sys_clk_in);
    tx_req_in <= 5'(1 << p);
    @(posedge sys_clk_in);
    tx_req_in <= 5'h00;
    @(posedge sys_clk_in);
    check(tx_grant_out[p] === g, "grant");
    q = tx_grant_queue_out[2*p +: 2];
  endtask : tx

  task automatic t_regs;
    logic [8:0] a [8];
    logic [7:0] v [8];
    a = '{9'h008, 9'h00C, 9'h010, 9'h014, 9'h094, 9'h0C0, 9'h0C4, 9'h0C8};
    v = '{8'h08, 8'h04, 8'h02, 8'h01, 8'h01, 8'h50, 8'hFA, 8'h80};
    for (int i = 0; i < 8; i++)
      rd(a[i], v[i], 2'h0);
    wr(9'h008, 8'hFF, 2'h0);
    rd(9'h008, 8'h7F, 2'h0);
    wr(9'h1FC, 8'h01, 2'h2);
    rd(9'h1FC, 8'h00, 2'h2);
  endtask : t_regs

  task automatic t_class;
    logic [16:0] d [8];
    logic [6:0] e [8];
    wr(9'h020, 8'h19, 2'h0);
    wr(9'h044, 8'h02, 2'h0);
    wr(9'h040, 8'h30, 2'h0);
    wr(9'h060, 8'h48, 2'h0);
    wr(9'h104, 8'h0C, 2'h0);
    d = '{dsc(1, 0, 0, 0, 0), dsc(1, 1, 0, 0, 0), dsc(2, 2, 1, 7, 0), dsc(2, 2, 1, 2, 0),
      dsc(2, 1, 0, 0, 0), dsc(3, 1, 1, 7, 0), dsc(3, 2, 0, 0, 8'h45), dsc(0, 2, 1, 7, 0)};
    e = '{7'h03, 7'h17, 7'h2F, 7'h25, 7'h16, 7'h11, 7'h2F, 7'h20};
    for (int i = 0; i < 8; i++)
      cls(d[i], e[i]);
    wr(9'h0C8, 8'h40, 2'h0);
    cls(dsc(3, 1, 0, 0, 0), 7'h15);
    rd(9'h140, 8'h09, 2'h0);
  endtask : t_class

  // Fill while the egress side stalls, then drain and confirm arrival order.
  task automatic t_fifo;
    int n;
    n = 0;
    @(posedge sys_clk_in);
    stall <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    desc_valid_in <= 1'b1;
    desc_data_in <= dsc(0, 0, 0, 0, 0);
    while (n < 40)
    begin
      @(posedge sys_clk_in);
      if (!desc_ready_out)
        break;
      n++;
      desc_data_in <= dsc(0, n % 5, 0, 0, 0);
    end
    desc_valid_in <= 1'b0;
    stall <= 1'b0;
    check(n == 17, "fill");
    for (int t = 0; t < 100 && i_qpc_egress_model.got.size() < n; t++)
      @(posedge sys_clk_in);
    check(i_qpc_egress_model.got.size() == n, "drain");
    for (int i = 0; i < n && i_qpc_egress_model.got.size() > 0; i++)
      check(i_qpc_egress_model.got.pop_front() === 7'((i % 5) * 16), "order");
  endtask : t_fifo

  task automatic t_sched;
    logic [1:0] q;
    int n3;
    wr(9'h004, 8'h02, 2'h0);
    q_nonempty_in <= 20'h00005;
    tx(0, 1'b1, q);
    check(q === 2'h2, "strict low");
    q_nonempty_in <= 20'h0F00F;
    tx(0, 1'b1, q);
    check(q === 2'h3, "strict high");
    tx(3, 1'b1, q);
    check(q === 2'h0, "single queue");
    q_nonempty_in <= 20'h0F000;
    tx(0, 1'b0, q);
    wr(9'h004, 8'h06, 2'h0);
    wr(9'h008, 8'h02, 2'h0);
    q_nonempty_in <= 20'h00009;
    n3 = 0;
    repeat (3) tx(0, 1'b1, q);
    repeat (6)
    begin
      tx(0, 1'b1, q);
      n3 += int'(q == 2'h3);
    end
    check(n3 == 4, "weighted share");
  endtask : t_sched

  // Cuts a hung run short well beyond the few hundred cycles the tests need.
  initial
  begin
    repeat (20000) @(posedge sys_clk_in);
    n_fail++;
    $display("MISMATCH %0t watchdog expired", $time);
    stop_test();
  end

  initial
  begin
    repeat (8) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    t_regs();
    t_class();
    t_fifo();
    t_sched();
    stop_test();
  end
endmodule : tb

`default_nettype wire
